// ==== hw/sfd_map.vh ====
// Register map, field layout and timing constants for the
// solenoid channel fault diagnostics block.
// Assumes a 100 MHz clock and a 32-bit classic Wishbone bus.
`ifndef SFD_MAP_VH
`define SFD_MAP_VH

// ----------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------
`define SFD_A_CFG0   8'h00
`define SFD_A_CFG1   8'h04
`define SFD_A_STAT   8'h08
`define SFD_A_MASK   8'h0c

// ----------------------------------------------------------
// Channel configuration fields
// ----------------------------------------------------------
`define SFD_F_AVG    9:0
`define SFD_F_SLEW   11:10
`define SFD_F_TYPE   12
`define SFD_F_SLOW   11
`define SFD_F_LO     7:0
`define SFD_F_HI     12:8
`define SFD_CFG_RST  13'h0000

// ----------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------
`define SFD_F_SHT    1:0
`define SFD_F_OPEN_OR_GROUND_FAULT_FLAG   3:2
`define SFD_F_REF    5:4
`define SFD_F_FLAGS  3:0
`define SFD_STAT_RST 4'h0
`define SFD_MASK_RST 4'h0

// ----------------------------------------------------------
// Timing, in printed units
// ----------------------------------------------------------
`define SFD_CLK_MHZ  100
`define SFD_SS_US    60
`define SFD_REF_MS   14
`define SFD_BLK1_US  5
`define SFD_BLK2_US  15
`define SFD_OSON_MS  12
`define SFD_FILT_US  60

// Lowest average-current command that counts as driven
`define SFD_MIN_CMD  10'h02a

`endif

// ==== hw/sfd_diag.v ====
// Fault diagnostics for two low-side solenoid channels.
// Assumes comparator outputs already synchronous to mclk and a
// current regulator that supplies the wanted gate state.
`timescale 1ns/1ps
`include "sfd_map.vh"

module sfd_diag #(
   parameter [20:0] SS_CYC   = `SFD_SS_US * `SFD_CLK_MHZ,
   parameter [20:0] REF_CYC  = `SFD_REF_MS * 1000 * `SFD_CLK_MHZ,
   parameter [20:0] OSON_CYC = `SFD_OSON_MS * 1000 * `SFD_CLK_MHZ,
   parameter [20:0] FILT_CYC = `SFD_FILT_US * `SFD_CLK_MHZ
) (
   input  wire        mclk,
   input  wire        rstn,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         irq,
   input  wire [1:0]  gate_req,
   input  wire [1:0]  plus_over_oc,
   input  wire [1:0]  plus_below_open,
   input  wire [1:0]  sense_minus_pin_low,
   output wire [1:0]  gate_on,
   output wire [1:0]  pull_up_en,
   output wire [1:0]  pull_down_en,
   output wire [9:0]  avg_cmd0,
   output wire [9:0]  avg_cmd1,
   output wire [1:0]  slew0,
   output wire [1:0]  slew1
);

   // ----------------------------------------------------------
   // Constants
   // ----------------------------------------------------------
   localparam [10:0] BLK1_CYC = `SFD_BLK1_US * `SFD_CLK_MHZ;
   localparam [10:0] BLK2_CYC = `SFD_BLK2_US * `SFD_CLK_MHZ;
   localparam [1:0]  ST_RUN   = 2'b01;
   localparam [1:0]  ST_REF   = 2'b10;

   // ----------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------
   // Qualification counter: restarts when condition drops
   function [20:0] fn_tick;
      input        cond;
      input [20:0] cnt;
      input [20:0] lim;
      begin
         if (!cond)
            fn_tick = 21'h0;
         else if (cnt < lim)
            fn_tick = cnt + 21'h1;
         else
            fn_tick = cnt;
      end
   endfunction

   // True on the cycle a counter reaches its limit
   function fn_hit;
      input        cond;
      input [20:0] cnt;
      input [20:0] lim;
      begin
         fn_hit = cond && (cnt == lim - 21'h1);
      end
   endfunction

   // ----------------------------------------------------------
   // Bus side storage
   // ----------------------------------------------------------
   reg  [12:0] cfg_st [0:1];
   reg  [3:0]  stat;
   reg  [3:0]  mask;
   wire [1:0]  ev_sht;
   wire [1:0]  ev_open_or_ground_fault_flag;
   wire [1:0]  in_ref;
   wire [12:0] act0;
   wire [12:0] act1;

   wire        req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr     = req & wb_we_i;
   wire        rd     = req & ~wb_we_i;
   wire        rd_st  = rd & (wb_adr_i == `SFD_A_STAT);
   wire [3:0]  ev_all = {ev_open_or_ground_fault_flag, ev_sht};

   // Sticky flags: a new event wins over a read clear
   wire [3:0]  next_stat = (rd_st ? 4'h0 : stat) | ev_all;

   // Acknowledge one cycle after the request, for any address
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req;
   end

   // Register writes with byte lanes
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_st[0] <= `SFD_CFG_RST;
         cfg_st[1] <= `SFD_CFG_RST;
         mask      <= `SFD_MASK_RST;
      end else if (wr) begin
         case (wb_adr_i)
            `SFD_A_CFG0: begin
               if (wb_sel_i[0])
                  cfg_st[0][`SFD_F_LO] <= wb_dat_i[`SFD_F_LO];
               if (wb_sel_i[1])
                  cfg_st[0][`SFD_F_HI] <= wb_dat_i[`SFD_F_HI];
            end
            `SFD_A_CFG1: begin
               if (wb_sel_i[0])
                  cfg_st[1][`SFD_F_LO] <= wb_dat_i[`SFD_F_LO];
               if (wb_sel_i[1])
                  cfg_st[1][`SFD_F_HI] <= wb_dat_i[`SFD_F_HI];
            end
            `SFD_A_MASK: begin
               if (wb_sel_i[0])
                  mask <= wb_dat_i[`SFD_F_FLAGS];
            end
            default: begin
               mask <= mask;
            end
         endcase
      end
   end

   // Status flags, cleared by a status read, held otherwise
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         stat <= `SFD_STAT_RST;
      else
         stat <= next_stat;
   end

   // Read data; unmapped addresses read as zero
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wb_dat_o <= 32'h0;
      end else if (rd) begin
         wb_dat_o <= 32'h0;
         case (wb_adr_i)
            `SFD_A_CFG0: wb_dat_o[12:0] <= cfg_st[0];
            `SFD_A_CFG1: wb_dat_o[12:0] <= cfg_st[1];
            `SFD_A_STAT: begin
               wb_dat_o[`SFD_F_FLAGS] <= stat;
               wb_dat_o[`SFD_F_REF]   <= in_ref;
            end
            `SFD_A_MASK: wb_dat_o[`SFD_F_FLAGS] <= mask;
            default:     wb_dat_o <= 32'h0;
         endcase
      end
   end

   // Level interrupt from unmasked sticky flags
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= |(next_stat & mask);
   end

   // ----------------------------------------------------------
   // Per-channel diagnostics
   // ----------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_ch
         reg  [12:0] act;
         reg  [1:0]  state;
         reg         gate_r;
         reg  [10:0] blk_cnt;
         reg  [20:0] oc_cnt;
         reg  [20:0] ref_cnt;
         reg  [20:0] on_cnt;
         reg  [20:0] pos_cnt;
         reg  [20:0] neg_cnt;

         wire run      = (state == ST_RUN);
         // Settings in force from the next edge on
         wire [12:0] next_act = run ? cfg_st[c] : act;
         wire driven   = (act[`SFD_F_AVG] >= `SFD_MIN_CMD);
         wire blanking = (blk_cnt != 11'h0);

         // Overcurrent qualified only when driven and unblanked
         wire oc_cond = run & gate_r & ~blanking
                        & driven
                        & plus_over_oc[c];
         wire oc_hit  = fn_hit(oc_cond, oc_cnt, SS_CYC);
         wire ref_end = (ref_cnt == REF_CYC - 21'h1);

         // Open/ground conditions: on-open while driven and on, plus-low only undriven, minus-low undriven or gate off
         wire on_cond  = driven & gate_r;
         wire pos_cond = ~driven & plus_below_open[c];
         wire neg_cond = (~driven | ~gate_r)
                         & sense_minus_pin_low[c];

         // Next gate: regulator request unless shut down
         wire next_gate = gate_req[c] & run & ~oc_hit;

         assign ev_sht[c]  = oc_hit;
         assign ev_open_or_ground_fault_flag[c] = fn_hit(on_cond, on_cnt, OSON_CYC)
                           | fn_hit(pos_cond, pos_cnt, FILT_CYC)
                           | fn_hit(neg_cond, neg_cnt, FILT_CYC);
         assign in_ref[c]       = state[1];
         assign gate_on[c]      = gate_r;
         // Typing bit steers only the plus pin current sources
         assign pull_up_en[c]   = act[`SFD_F_TYPE];
         assign pull_down_en[c] = ~act[`SFD_F_TYPE];

         // Shutdown and refresh sequencer
         always @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               state   <= ST_RUN;
               ref_cnt <= 21'h0;
            end else begin
               case (state)
                  ST_RUN: begin
                     ref_cnt <= 21'h0;
                     if (oc_hit)
                        state <= ST_REF;
                  end
                  ST_REF: begin
                     if (ref_end) begin
                        state   <= ST_RUN;
                        ref_cnt <= 21'h0;
                     end else begin
                        ref_cnt <= ref_cnt + 21'h1;
                     end
                  end
                  default: begin
                     state   <= ST_RUN;
                     ref_cnt <= 21'h0;
                  end
               endcase
            end
         end

         // Active settings follow stored ones outside refresh
         always @(posedge mclk or negedge rstn) begin
            if (!rstn)
               act <= `SFD_CFG_RST;
            else
               act <= next_act;
         end

         // Gate drive, forced off during refresh
         always @(posedge mclk or negedge rstn) begin
            if (!rstn)
               gate_r <= 1'b0;
            else
               gate_r <= next_gate;
         end

         // Blanking window loaded on each off-to-on edge
         always @(posedge mclk or negedge rstn) begin
            if (!rstn)
               blk_cnt <= 11'h0;
            else if (next_gate & ~gate_r)
               blk_cnt <= next_act[`SFD_F_SLOW] ? BLK2_CYC
                                                : BLK1_CYC;
            else if (blanking)
               blk_cnt <= blk_cnt - 11'h1;
         end

         // Qualification timers, one set per channel
         always @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               oc_cnt  <= 21'h0;
               on_cnt  <= 21'h0;
               pos_cnt <= 21'h0;
               neg_cnt <= 21'h0;
            end else begin
               oc_cnt  <= fn_tick(oc_cond, oc_cnt, SS_CYC);
               on_cnt  <= fn_tick(on_cond, on_cnt, OSON_CYC);
               pos_cnt <= fn_tick(pos_cond, pos_cnt, FILT_CYC);
               neg_cnt <= fn_tick(neg_cond, neg_cnt, FILT_CYC);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------
   // Active settings toward the current regulator
   // ----------------------------------------------------------
   assign act0     = g_ch[0].act;
   assign act1     = g_ch[1].act;
   assign avg_cmd0 = act0[`SFD_F_AVG];
   assign avg_cmd1 = act1[`SFD_F_AVG];
   assign slew0    = act0[`SFD_F_SLEW];
   assign slew1    = act1[`SFD_F_SLEW];

endmodule

// ==== bench/sfd_load.sv ====
// Load and sense network model for two solenoid channels.
// Assumes a fault kind per channel from the bench: 0 fine,
// 1 short to battery, 2 open load, 3 short to ground.
`timescale 1ns/1ps
module sfd_load (
   input  wire       mclk,
   input  wire [3:0] kind,
   input  wire [1:0] gate_on,
   input  wire [1:0] pull_up_en,
   output reg  [1:0] plus_over_oc,
   output reg  [1:0] plus_below_open,
   output reg  [1:0] sense_minus_pin_low
);
   integer i;
   initial {plus_over_oc, plus_below_open, sense_minus_pin_low} = 6'h00;
   // Plus comparators follow the load one clock late, the minus one two; an open pin
   // falls only while the pull-down source pulls it
   always @(posedge mclk) begin
      for (i = 0; i < 2; i = i + 1) begin
         plus_over_oc[i] <= gate_on[i] && kind[2*i+:2] == 2'h1;
         plus_below_open[i] <= kind[2*i+:2] == 2'h3 ||
            (kind[2*i+:2] == 2'h2 && !pull_up_en[i]);
         sense_minus_pin_low[i] <= plus_below_open[i];
      end
   end
endmodule

// ==== bench/sfd_diag_props.sv ====
// Assertions on bus answers and overcurrent timing of sfd_diag.
// Assumes it is bound to sfd_diag and sees only its ports.
`timescale 1ns/1ps
`include "sfd_map.vh"
module sfd_diag_props (
   input logic       mclk,
   input logic       rstn,
   input logic       wb_cyc_i,
   input logic       wb_stb_i,
   input logic       wb_ack_o,
   input logic [1:0] gate_req,
   input logic [1:0] plus_over_oc,
   input logic [1:0] gate_on,
   input logic [1:0] pull_up_en,
   input logic [1:0] pull_down_en,
   input logic [9:0] avg_cmd0
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [10:0] on_cnt;
   // Cycles channel 0 has been on, saturating
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         on_cnt <= 11'h000;
      else if (!gate_on[0])
         on_cnt <= 11'h000;
      else if (on_cnt != 11'h7ff)
         on_cnt <= on_cnt + 11'h001;
   end
   // Gate dropped while still requested
   sequence cut0;
      $fell(gate_on[0]) && $past(gate_req[0]);
   endsequence
   sequence cut1;
      $fell(gate_on[1]) && $past(gate_req[1]);
   endsequence
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   pull_pair_a: assert property (pull_up_en == ~pull_down_en)
      else $error("pull sources not exclusive");
   oc_held0_a: assert property (cut0 |->
      $past(plus_over_oc[0]) && $past(plus_over_oc[0], 8))
      else $error("channel 0 cut without held overcurrent");
   oc_held1_a: assert property (cut1 |->
      $past(plus_over_oc[1]) && $past(plus_over_oc[1], 8))
      else $error("channel 1 cut without held overcurrent");
   oc_blank_a: assert property (cut0 |-> on_cnt >= 11'd500)
      else $error("cut inside blanking");
   oc_min_a: assert property (cut0 |->
      $past(avg_cmd0) >= `SFD_MIN_CMD)
      else $error("cut below minimum command");
   refresh_hold_a: assert property (cut0 |-> (!gate_on[0]) [*8])
      else $error("gate back too early");
endmodule
bind sfd_diag sfd_diag_props i_props (
   .mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .gate_req(gate_req),
   .plus_over_oc(plus_over_oc), .gate_on(gate_on),
   .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
   .avg_cmd0(avg_cmd0));

// ==== bench/sfd_diag_bench.sv ====
// Self-checking bench for sfd_diag driving a two-channel load model.
// Assumes sfd_load and the bound checker compile first.
`timescale 1ns/1ps
`include "sfd_map.vh"
module sfd_diag_bench;
   logic        mclk = 1'b0, rstn = 1'b0, cs = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0]  gate_req = 2'h0;
   logic [3:0]  kind = 4'h0;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, irq;
   wire  [1:0]  gate_on, pull_up_en, pull_down_en, slew0, slew1;
   wire  [1:0]  plus_over_oc, plus_below_open, sense_minus_pin_low;
   wire  [9:0]  avg_cmd0, avg_cmd1;
   int          error_cnt = 0, checked = 0, nw;

   // Shortened counts: sense 20, refresh 50, on-open 40, filter 20
   sfd_diag #(.SS_CYC(21'h14), .REF_CYC(21'h32), .OSON_CYC(21'h28),
      .FILT_CYC(21'h14)) i_dut (
      .mclk, .rstn, .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o,
      .wb_ack_o, .irq, .gate_req, .plus_over_oc, .plus_below_open,
      .sense_minus_pin_low, .gate_on, .pull_up_en, .pull_down_en,
      .avg_cmd0, .avg_cmd1, .slew0, .slew1);
   sfd_load i_load (.mclk, .kind, .gate_on, .pull_up_en, .plus_over_oc,
      .plus_below_open, .sense_minus_pin_low);

   task end_sim;
      if (error_cnt == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked = checked + 1;
      if (s !== e) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task tmo;
      chk("wait bound", 32'h0, 32'h1);
      end_sim;
   endtask
   // One classic Wishbone cycle; read data lands in rd
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      {cs, we, adr, wd} <= {1'b1, w, a, d};
      do begin
         @(posedge mclk);
         n = n + 1;
      end while (wb_ack_o !== 1'b1 && n < 9);
      rd = wb_dat_o;
      cs <= 1'b0;
      if (wb_ack_o !== 1'b1)
         tmo;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), rd & m, e);
   endtask
   // Bounded wait for gate c to reach v; nw counts the cycles
   task wg(input int c, input logic v, input int lim);
      nw = 0;
      while (gate_on[c] !== v && nw < lim) begin
         @(posedge mclk);
         nw = nw + 1;
      end
      if (gate_on[c] !== v)
         tmo;
   endtask

   task sc_reset;
      chk("reset pins", {gate_on, pull_up_en, pull_down_en, irq}, 7'h06);
      rdc(`SFD_A_CFG0, 32'h1fff, 32'h0);
      rdc(`SFD_A_MASK, 32'hf, 32'h0);
      rdc(`SFD_A_STAT, 32'h3f, 32'h0);
      rdc(8'h10, 32'hffffffff, 32'h0);
   endtask
   // Short to battery on channel 0, retried with fast then slow blanking
   task sc_oc;
      wb(1'b1, `SFD_A_CFG0, 32'h100);
      wb(1'b1, `SFD_A_CFG1, 32'h100);
      wb(1'b1, `SFD_A_MASK, 32'h1);
      gate_req <= 2'b11;
      kind <= 4'h1;
      wg(0, 1'b1, 9);
      wg(0, 1'b0, 2000);
      chk("blank fast", nw > 514 && nw < 536, 1);
      repeat (20) @(posedge mclk);
      chk("gates", gate_on, 2'b10);
      chk("irq", irq, 1'b1);
      wb(1'b1, `SFD_A_CFG0, 32'h950);
      chk("held cfg", {slew0, avg_cmd0}, 12'h100);
      rdc(`SFD_A_STAT, 32'h3f, 32'h1d);
      wg(0, 1'b1, 99);
      chk("new cfg", {slew0, avg_cmd0}, 12'h950);
      wg(0, 1'b0, 2000);
      chk("blank slow", nw > 1514 && nw < 1536, 1);
      kind <= 4'h0;
      rdc(`SFD_A_STAT, 32'h3, 32'h1);
      wg(0, 1'b1, 99);
      rdc(`SFD_A_STAT, 32'h3, 32'h0);
      chk("irq clear", irq, 1'b0);
      gate_req <= 2'b00;
   endtask
   task sc_min;
      wb(1'b1, `SFD_A_CFG1, 32'h029);
      kind <= 4'h4;
      gate_req <= 2'b10;
      repeat (700) @(posedge mclk);
      chk("below min", gate_on[1], 1'b1);
      wb(1'b1, `SFD_A_CFG1, {22'h0, `SFD_MIN_CMD});
      wg(1, 1'b0, 99);
      kind <= 4'h0;
      gate_req <= 2'b00;
   endtask
   // Minus pin low on an off channel: short bursts, then held
   task sc_minus;
      wb(1'b1, `SFD_A_CFG1, 32'h100);
      repeat (60) @(posedge mclk);
      chk("cfg1 out", {slew1, avg_cmd1}, 12'h100);
      wb(1'b0, `SFD_A_STAT, 32'h0);
      repeat (2) begin
         kind <= 4'hc;
         repeat (15) @(posedge mclk);
         kind <= 4'h0;
         repeat (5) @(posedge mclk);
      end
      rdc(`SFD_A_STAT, 32'h8, 32'h0);
      kind <= 4'hc;
      repeat (30) @(posedge mclk);
      rdc(`SFD_A_STAT, 32'h8, 32'h8);
      kind <= 4'h0;
   endtask
   // Fault typing at zero current: open, then ground short
   task sc_type;
      wb(1'b1, `SFD_A_CFG0, 32'h0);
      gate_req <= 2'b01;
      kind <= 4'h2;
      repeat (30) @(posedge mclk);
      chk("pull down", pull_down_en[0], 1'b1);
      rdc(`SFD_A_STAT, 32'h4, 32'h4);
      repeat (3) wb(1'b1, `SFD_A_CFG0, 32'h1000);
      chk("typing", {gate_on[0], pull_up_en[0], pull_down_en[0],
         avg_cmd0}, 13'h1800);
      wb(1'b0, `SFD_A_STAT, 32'h0);
      repeat (30) @(posedge mclk);
      rdc(`SFD_A_STAT, 32'h4, 32'h0);
      kind <= 4'h3;
      repeat (30) @(posedge mclk);
      rdc(`SFD_A_STAT, 32'h4, 32'h4);
   endtask

   initial forever #5 mclk = ~mclk;
   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      sc_reset;
      sc_oc;
      sc_min;
      sc_minus;
      sc_type;
      end_sim;
   end
endmodule
